// [link_training_coef_override_regs.sv]
// APB register bank for link training coefficient overrides and lane status.
`timescale 1ns/1ps
`include "lt_regs_cfg.svh"

// Overview of operation
// R1 - Writing 1 to the lane 2 local update bit applies the lane 2 local transmit coefficients.
// R2 - Writing 1 to the lane 3 local update bit applies the lane 3 local transmit coefficients.
// R3 - Each local update bit clears itself, and writing 0 to it changes nothing.
// R4 - Local update bits act only while the local override enable is 1 and are ignored otherwise.
// R5 - Lane 1 status is a read-only six-bit copy of the lane 0 status layout.
// R6 - Lane 2 and lane 3 status are read-only six-bit fields with the lane 0 layout.
// R7 - Software judges a frame lock error unrecoverable when the lane tap settings are initial.
// R8 - The lane 0 local request field follows the low six bits of the sent frame first word.
// R9 - The lane 0 local request field is writable only while the partner override enable is set.
// R10 - The upper pair encodes decrement as 10, hold as 00, and 11 is reserved.
// R11 - The middle and lowest pairs use the same two-bit encoding as the upper pair.
// R12 - Software sets the partner override enable and then the lane 0 send bit to transmit.
// R13 - Code 01 in any pair means increment.
// R14 - A self-clearing bit reads 0 from the cycle after the engine registers the request.
module link_training_coef_override_regs
    import lt_regs_pkg::*;
#(
    parameter int LANES = 4
) (
    input  wire logic               core_clk,
    input  wire logic               srst,
    input  wire logic               psel,
    input  wire logic               penable,
    input  wire logic               pwrite,
    input  wire logic [11:0]        paddr,
    input  wire logic [31:0]        pwdata,
    output logic      [31:0]        prdata,
    output logic                    pready,
    output logic                    pslverr,
    input  wire logic [8*LANES-1:0] lane_coef,
    input  wire logic [6*LANES-1:0] lane_status,
    input  wire logic [5:0]         tx_frame_word,
    output logic      [LANES-1:0]   coef_apply,
    output logic      [8*LANES-1:0] applied_coef,
    output logic                    partner_send,
    output logic      [5:0]         local_coef_request_field,
    output logic                    partner_coef_override_enable,
    output logic                    irq
);

    // Bus state and register storage.
    logic              pready_ff;
    logic              pslverr_ff;
    logic [31:0]       prdata_ff;
    logic [1:0]        override_ff;
    logic [LANES-1:0]  local_req_ff;
    logic              send_req_ff;
    logic [LANES-1:0]  apply_ff;
    logic [8*LANES-1:0] applied_ff;
    logic              send_ff;
    logic [5:0]        field_ff;
    logic [4:0]        irq_status_ff;
    logic [4:0]        irq_mask_ff;
    logic              irq_ff;

    // Address decode; printed offsets are word indices, so the byte address is four times that.
    wire logic [9:0] word_idx   = paddr[11:2];
    wire logic       access     = psel & penable;
    wire logic       wr_en      = access & pready_ff & pwrite;
    wire logic       rd_take    = access & ~pready_ff;
    wire logic       hit_ovr    = (word_idx == `IDX_OVERRIDE_CTRL);
    wire logic       hit_req    = (word_idx == `IDX_UPDATE_REQUEST);
    wire logic       hit_stat   = (word_idx == `IDX_LANE_STATUS);
    wire logic       hit_coef   = (word_idx == `IDX_LOCAL_COEF);
    wire logic       hit_ists   = (word_idx == `IDX_IRQ_STATUS);
    wire logic       hit_imsk   = (word_idx == `IDX_IRQ_MASK);
    wire logic       mapped     = hit_ovr | hit_req | hit_stat | hit_coef | hit_ists | hit_imsk;
    wire logic       local_ovr  = override_ff[1];
    wire logic       partner_ovr = override_ff[0];

    // Request writes are dropped unless the matching override is on.
    wire logic [LANES-1:0] local_wr =
        (wr_en & hit_req & local_ovr) ? pwdata[`POS_LOCAL_REQ +: LANES] : '0; // R4
    wire logic send_wr = wr_en & hit_req & partner_ovr & pwdata[`BIT_PARTNER_SEND];

    // Reserved codes written by software are stored as hold so the engine never sees them.
    function automatic logic [1:0] clean_pair(input logic [1:0] code);
        clean_pair = (code == COEF_RSVD) ? 2'(COEF_HOLD) : code; // R10
    endfunction : clean_pair

    wire logic [5:0] field_wdata = {clean_pair(pwdata[5:4]), // R10
                                    clean_pair(pwdata[3:2]), // R11
                                    clean_pair(pwdata[1:0])}; // R11
    wire logic       field_wr    = wr_en & hit_coef & partner_ovr; // R9
    wire logic [5:0] nxt_field   = field_wr ? field_wdata :
                                   (partner_ovr ? field_ff : tx_frame_word); // R8

    // Status word: four six-bit lane fields on byte boundaries.
    wire logic [31:0] status_word = {2'h0, lane_status[23:18], 2'h0, lane_status[17:12], // R6
                                     2'h0, lane_status[11:6], 2'h0, lane_status[5:0]}; // R5
    wire logic [31:0] req_word    = {20'h0, local_req_ff, 3'h0, send_req_ff, 4'h0}; // R14

    wire logic [31:0] rd_mux =
        hit_ovr  ? {14'h0, override_ff, 16'h0} :
        hit_req  ? req_word :
        hit_stat ? status_word :
        hit_coef ? {26'h0, field_ff} :
        hit_ists ? {27'h0, irq_status_ff} :
        hit_imsk ? {27'h0, irq_mask_ff} : 32'h0;

    // Events: each applied lane request and each partner send.
    wire logic [4:0] events   = {send_ff, apply_ff};
    wire logic [4:0] w1c      = (wr_en & hit_ists) ? pwdata[4:0] : 5'h00;
    // Set wins over clear so an event landing on the clearing write is kept.
    wire logic [4:0] nxt_ists = (irq_status_ff & ~w1c) | events;

    // APB handshake: one wait state, so every access ends on the second access-phase edge.
    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            pready_ff  <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff  <= 32'h0;
        end
        else
        begin
            pready_ff  <= rd_take;
            pslverr_ff <= rd_take & ~mapped;
            if (rd_take)
                prdata_ff <= pwrite ? 32'h0 : rd_mux;
        end
    end

    // Override enables written by software.
    always_ff @(posedge core_clk)
    begin
        if (srst)
            override_ff <= `RST_OVERRIDE;
        else if (wr_en & hit_ovr)
            override_ff <= {pwdata[`BIT_LOCAL_OVR], pwdata[`BIT_PARTNER_OVR]};
    end

    // Self-clearing requests: held one cycle, then taken by the engine as a pulse.
    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            local_req_ff <= '0;
            send_req_ff  <= 1'b0;
            apply_ff     <= '0;
            send_ff      <= 1'b0;
        end
        else
        begin
            local_req_ff <= local_wr; // R3
            send_req_ff  <= send_wr;
            apply_ff     <= local_req_ff & {LANES{local_ovr}}; // R4
            send_ff      <= send_req_ff & partner_ovr;
        end
    end

    // Coefficients are captured from the lane's value field when its request is taken.
    always_ff @(posedge core_clk)
    begin
        if (srst)
            applied_ff <= '0;
        else
            for (int i = 0; i < LANES; i++)
                if (local_req_ff[i] & local_ovr)
                    applied_ff[8*i +: 8] <= lane_coef[8*i +: 8]; // R1 R2
    end

    // Lane 0 local request field, interrupt status, mask and line.
    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            field_ff      <= `RST_FIELD;
            irq_status_ff <= `RST_IRQ;
            irq_mask_ff   <= `RST_IRQ;
            irq_ff        <= 1'b0;
        end
        else
        begin
            field_ff      <= nxt_field;
            irq_status_ff <= nxt_ists;
            if (wr_en & hit_imsk)
                irq_mask_ff <= pwdata[4:0];
            irq_ff        <= |(irq_status_ff & irq_mask_ff);
        end
    end

    assign prdata                       = prdata_ff;
    assign pready                       = pready_ff;
    assign pslverr                      = pslverr_ff;
    assign coef_apply                   = apply_ff;
    assign applied_coef                 = applied_ff;
    assign partner_send                 = send_ff;
    assign local_coef_request_field     = field_ff;
    assign partner_coef_override_enable = override_ff[0];
    assign irq                          = irq_ff;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (srst);

    // Lane 2 request with override on gives an apply pulse with the lane 2 coefficients.
    lane2_apply_a : assert property ( // R1
        local_wr[2] |=> ##1 (coef_apply[2] && applied_coef[23:16] == $past(lane_coef[23:16])))
        else $error("lane 2 request did not apply its coefficients");

    // Lane 3 likewise.
    lane3_apply_a : assert property ( // R2
        local_wr[3] |=> ##1 (coef_apply[3] && applied_coef[31:24] == $past(lane_coef[31:24])))
        else $error("lane 3 request did not apply its coefficients");

    // A lane 2 apply pulse lasts exactly one cycle.
    apply_single_a : assert property ( // R3
        coef_apply[2] |=> !coef_apply[2])
        else $error("apply pulse longer than one cycle");

    // With the local override off, a request write never yields a pulse.
    ignore_off_a : assert property ( // R4
        (wr_en && hit_req && !local_ovr) |=> ##1 (coef_apply == '0) [*2])
        else $error("request acted while local override off");

    // Lane 1 status reads back in bits 13:8.
    stat_l1_a : assert property ( // R5
        (rd_take && hit_stat && !pwrite) |=> prdata[13:8] == $past(lane_status[11:6]))
        else $error("lane 1 status read mismatch");

    // Lanes 2 and 3 status read back in their fields.
    stat_l23_a : assert property ( // R6
        (rd_take && hit_stat && !pwrite) |=>
        (prdata[21:16] == $past(lane_status[17:12]) && prdata[29:24] == $past(lane_status[23:18])))
        else $error("lane 2 or 3 status read mismatch");

    // Without the partner override the field follows the transmitted word.
    field_follow_a : assert property ( // R8
        !partner_ovr |=> local_coef_request_field == $past(tx_frame_word))
        else $error("local request field not following frame word");

    // With the partner override set and no write, the field holds.
    field_hold_a : assert property ( // R9
        (partner_ovr && !field_wr) |=> $stable(local_coef_request_field))
        else $error("local request field changed without a write");

    // No pair ever carries the reserved code after a software write.
    field_code_a : assert property ( // R10 R11 R13
        field_wr |=> (local_coef_request_field[5:4] != COEF_RSVD
                      && local_coef_request_field[3:2] != COEF_RSVD
                      && local_coef_request_field[1:0] != COEF_RSVD))
        else $error("reserved code stored in local request field");

    // A request bit reads 0 two cycles after it was written.
    req_clear_a : assert property ( // R14
        local_wr[2] |=> local_req_ff[2] ##1 !local_req_ff[2])
        else $error("request bit did not self clear");

    // By the time the engine pulses, the bit is already clear, so a poll can never see it late.
    req_gone_a : assert property ( // R14
        coef_apply[2] |-> !local_req_ff[2])
        else $error("request bit still set at apply");

    // A lane 3 pulse needs its pending request and the local override one cycle earlier.
    apply_gate_a : assert property ( // R2 R4
        coef_apply[3] |-> $past(local_req_ff[3] && local_ovr))
        else $error("lane 3 applied without an enabled request");

    // The partner send pulse needs a pending send and the partner override.
    send_gate_a : assert property (
        partner_send |-> $past(send_req_ff && partner_ovr))
        else $error("partner send without an enabled request");

    // Override enables take the written bits at the write edge.
    ovr_write_a : assert property ( // R4 R9
        (wr_en && hit_ovr) |=>
        override_ff == {$past(pwdata[`BIT_LOCAL_OVR]), $past(pwdata[`BIT_PARTNER_OVR])})
        else $error("override enables not written");

    // Every access phase is answered after exactly one wait state.
    ready_wait_a : assert property (
        (psel && penable && !pready) |=> pready)
        else $error("access phase not answered after one wait state");

    // The answer is a one-cycle pulse; a request still held after it is taken again in the next cycle.
    ready_pulse_a : assert property (
        pready |=> !pready)
        else $error("pready held longer than one cycle");

    // An unmapped index is refused with an error and zero read data.
    unmapped_err_a : assert property (
        (rd_take && !mapped) |=> (pslverr && pready && prdata == 32'h0))
        else $error("unmapped access not refused");

    // The error flag only ever rides on the answering cycle.
    err_with_ready_a : assert property (
        pslverr |-> pready)
        else $error("pslverr without pready");

    // An apply event sets its status bit even when a clearing write lands with it.
    ists_set_a : assert property (
        coef_apply[2] |=> irq_status_ff[2])
        else $error("apply event lost from interrupt status");

    // Writing one clears a status bit when no new event arrives in the same cycle.
    ists_clear_a : assert property (
        (wr_en && hit_ists && pwdata[2] && !coef_apply[2]) |=> !irq_status_ff[2])
        else $error("status bit not cleared by writing one");

    // The interrupt line follows the masked status with one cycle of lag.
    irq_level_a : assert property (
        irq == $past(|(irq_status_ff & irq_mask_ff)))
        else $error("interrupt line does not follow masked status");

endmodule : link_training_coef_override_regs

// [link_training_coef_override_regs_bench.sv]
// Self-checking testbench for the link training coefficient override register bank.
`timescale 1ns/1ps
`include "lt_regs_cfg.svh"
`define CHK(nm, e, a) begin checked++; if ((a) !== (e)) begin n_errors++; \
    $display("CHECK FAILED %s expected %0h seen %0h", nm, e, a); end end
module link_training_coef_override_regs_bench;
    import lt_regs_pkg::*;
    logic        core_clk;
    logic        srst        = 1'b1;
    logic        psel        = 1'b0;
    logic        penable     = 1'b0;
    logic        pwrite      = 1'b0;
    logic [11:0] paddr       = 12'h000;
    logic [31:0] pwdata      = 32'h00000000;
    logic [31:0] lane_coef   = 32'hA1B2C3D4;
    logic [23:0] lane_status = {6'h2B, 6'h1C, 6'h35, 6'h0E};
    logic [5:0]  tx_word     = 6'h15;
    logic [31:0] prdata, applied_coef, rd;
    logic [3:0]  coef_apply;
    logic [3:0]  last_apply  = 4'h0;
    logic [5:0]  field;
    logic        pready, pslverr, partner_send, ovr_en, irq, er;
    int          n_errors    = 0;
    int          checked     = 0;
    int          n_apply     = 0;
    int          n_send      = 0;
    int          cyc         = 0;
    int          base;

    link_training_coef_override_regs dut (.core_clk(core_clk), .srst(srst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .lane_coef(lane_coef), .lane_status(lane_status),
        .tx_frame_word(tx_word), .coef_apply(coef_apply), .applied_coef(applied_coef),
        .partner_send(partner_send), .local_coef_request_field(field),
        .partner_coef_override_enable(ovr_en), .irq(irq));

    // Free-running 250 MHz clock.
    initial
    begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end

    // Apply pulses last one cycle, so they are counted here rather than polled by the tasks.
    always @(posedge core_clk)
    begin
        cyc <= cyc + 1;
        if (coef_apply != 4'h0)
        begin
            n_apply    <= n_apply + 1;
            last_apply <= coef_apply;
        end
        if (partner_send)
            n_send <= n_send + 1;
        if (cyc == 3000)
        begin
            n_errors++;
            wrap_up();
        end
    end

    // One APB transfer; it holds the request until pready and leaves one idle cycle after.
    task automatic apb(input logic w, input logic [9:0] idx, input logic [31:0] d);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= {idx, 2'b00};
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        @(posedge core_clk);
        while (pready !== 1'b1) @(posedge core_clk);
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge core_clk);
    endtask : apb

    task automatic pause();
        repeat (6) @(posedge core_clk);
    endtask : pause

    // Reset values, and the lane 0 field following the transmitted frame word.
    task automatic t_reset();
        `CHK("irq", 1'b0, irq)
        apb(0, `IDX_OVERRIDE_CTRL, 0);
        `CHK("ovr", 32'h0, rd)
        apb(0, `IDX_LOCAL_COEF, 0);
        `CHK("field", 32'h15, rd)
        tx_word <= 6'h2A;
        apb(0, `IDX_LOCAL_COEF, 0);
        `CHK("field", 32'h2A, rd)
    endtask : t_reset

    // Requests written while the local override is off must do nothing.
    task automatic t_ignored();
        base = n_apply;
        apb(1, `IDX_UPDATE_REQUEST, 32'hF00);
        pause();
        `CHK("apply", 0, n_apply - base)
        apb(0, `IDX_UPDATE_REQUEST, 0);
        `CHK("req", 32'h0, rd)
    endtask : t_ignored

    // Lane 2 and lane 3 requests apply their own coefficients and clear themselves.
    task automatic t_apply();
        apb(1, `IDX_OVERRIDE_CTRL, 32'h00020000);
        base = n_apply;
        apb(1, `IDX_UPDATE_REQUEST, 32'h400);
        pause();
        `CHK("lane", 4'h4, last_apply)
        `CHK("coef2", 8'hB2, applied_coef[23:16])
        apb(0, `IDX_UPDATE_REQUEST, 0);
        `CHK("req", 32'h0, rd)
        apb(1, `IDX_UPDATE_REQUEST, 32'h800);
        pause();
        `CHK("lane", 4'h8, last_apply)
        `CHK("coef3", 8'hA1, applied_coef[31:24])
        apb(1, `IDX_UPDATE_REQUEST, 32'h0);
        pause();
        `CHK("count", 2, n_apply - base)
    endtask : t_apply

    // The lane 0 field is writable only under partner override; reserved pairs read as hold.
    task automatic t_field();
        apb(1, `IDX_LOCAL_COEF, 32'h24);
        apb(0, `IDX_LOCAL_COEF, 0);
        `CHK("field", 32'h2A, rd)
        apb(1, `IDX_OVERRIDE_CTRL, 32'h00030000);
        `CHK("ovr_en", 1'b1, ovr_en)
        apb(1, `IDX_LOCAL_COEF, 32'h24);
        apb(0, `IDX_LOCAL_COEF, 0);
        `CHK("field", 32'h24, rd)
        apb(1, `IDX_LOCAL_COEF, 32'h39);
        apb(0, `IDX_LOCAL_COEF, 0);
        `CHK("field", 32'h09, rd)
        apb(1, `IDX_LOCAL_COEF, 32'h0E);
        apb(0, `IDX_LOCAL_COEF, 0);
        `CHK("field", 32'h02, rd)
        apb(1, `IDX_OVERRIDE_CTRL, 32'h0);
        apb(0, `IDX_LOCAL_COEF, 0);
        `CHK("field", 32'h2A, rd)
    endtask : t_field

    // Lane status fields are read-only copies of the lane inputs.
    task automatic t_status();
        apb(1, `IDX_LANE_STATUS, 32'hFFFFFFFF);
        apb(0, `IDX_LANE_STATUS, 0);
        `CHK("status", 32'h2B1C350E, rd)
    endtask : t_status

    // The send bit needs the partner override first; then one pulse and its interrupt bit.
    task automatic t_send();
        base = n_send;
        apb(1, `IDX_UPDATE_REQUEST, 32'h10);
        pause();
        `CHK("send_off", 0, n_send - base)
        apb(1, `IDX_OVERRIDE_CTRL, 32'h00010000);
        apb(1, `IDX_IRQ_STATUS, 32'h1F);
        apb(1, `IDX_IRQ_MASK, 32'h10);
        apb(1, `IDX_UPDATE_REQUEST, 32'h10);
        pause();
        `CHK("send", 1, n_send - base)
        `CHK("irq", 1'b1, irq)
        apb(0, `IDX_UPDATE_REQUEST, 0);
        `CHK("req", 32'h0, rd)
    endtask : t_send

    // Interrupt raised, cleared and masked, then an unmapped access.
    task automatic t_irq();
        apb(1, `IDX_OVERRIDE_CTRL, 32'h00020000);
        apb(1, `IDX_IRQ_STATUS, 32'h1F);
        apb(1, `IDX_IRQ_MASK, 32'h04);
        apb(1, `IDX_UPDATE_REQUEST, 32'h400);
        pause();
        `CHK("irq", 1'b1, irq)
        apb(0, `IDX_IRQ_STATUS, 0);
        `CHK("irq_st", 32'h4, rd)
        apb(1, `IDX_IRQ_STATUS, 32'h4);
        pause();
        `CHK("irq", 1'b0, irq)
        apb(1, `IDX_UPDATE_REQUEST, 32'h800);
        pause();
        `CHK("irq", 1'b0, irq)
        apb(0, `IDX_IRQ_STATUS, 0);
        `CHK("irq_st", 32'h8, rd)
        apb(0, 10'h0FF, 0);
        `CHK("slverr", 1'b1, er)
        `CHK("rdata", 32'h0, rd)
    endtask : t_irq

    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : wrap_up

    // Reset for 20 cycles, then run every scenario in turn.
    initial
    begin
        repeat (20) @(posedge core_clk);
        srst <= 1'b0;
        @(posedge core_clk);
        t_reset();
        t_ignored();
        t_apply();
        t_field();
        t_status();
        t_irq();
        t_send();
        wrap_up();
    end
endmodule : link_training_coef_override_regs_bench

// [lt_regs_cfg.svh]
// Register indices, field positions and reset values of the link training register bank.
`ifndef LT_REGS_CFG_SVH
`define LT_REGS_CFG_SVH
`define IDX_OVERRIDE_CTRL   10'h0D0
`define IDX_UPDATE_REQUEST  10'h0D1
`define IDX_LANE_STATUS     10'h0D2
`define IDX_LOCAL_COEF      10'h0D4
`define IDX_IRQ_STATUS      10'h0F0
`define IDX_IRQ_MASK        10'h0F1
`define BIT_PARTNER_OVR     16
`define BIT_LOCAL_OVR       17
`define BIT_PARTNER_SEND    4
`define POS_LOCAL_REQ       8
`define POS_STATUS_L1       8
`define POS_STATUS_L2       16
`define POS_STATUS_L3       24
`define RST_OVERRIDE        2'h0
`define RST_FIELD           6'h00
`define RST_IRQ             5'h00
`endif

// [lt_regs_pkg.sv]
// Types shared by the link training register bank.
package lt_regs_pkg;
    // Two-bit coefficient request code: hold, increment, decrement, reserved.
    typedef enum logic [1:0] {COEF_HOLD, COEF_INC, COEF_DEC, COEF_RSVD} coef_req_t;
    typedef logic [5:0] lane_status_t;
endpackage : lt_regs_pkg
